// [pkg/aoc_pkg.sv]
package aoc_pkg;
	localparam int WORD_W     = 14;
	localparam int REG_ADDR_W = 4;
	localparam int REG_DATA_W = 16;
	localparam int FMT_W      = 2;

	localparam logic [REG_ADDR_W-1:0] ADDR_CTRL   = 4'h0;
	localparam logic [REG_ADDR_W-1:0] ADDR_STATUS = 4'h1;

	localparam int CTRL_BYPASS_BIT = 0;
	localparam int CTRL_PD_BIT     = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	localparam int STAT_CLK_BIT    = 0;
	localparam int STAT_PD_BIT     = 1;
	localparam int STAT_LOCK_BIT   = 2;
	localparam int STAT_RANGE_BIT  = 3;
	localparam int STAT_BYPASS_BIT = 4;

	localparam int FMT_TWOS_BIT = 0;
	localparam int FMT_FALL_BIT = 1;

	localparam int CLK_PERIOD_NS     = 50;
	localparam int CLOCK_LOSS_NS     = 1000;
	localparam int CLOCK_LOSS_CYCLES = (CLOCK_LOSS_NS / CLK_PERIOD_NS < 1) ? 1 :
		CLOCK_LOSS_NS / CLK_PERIOD_NS;
	localparam int IDLE_W = 6;

	localparam int LATENCY_HALF = 33;
	localparam int LOCK_EDGES   = 8;
	localparam int LOCK_W       = 4;

	localparam int SERIAL_BITS = 16;
	localparam int SER_CNT_W   = 5;
	localparam int SER_ADDR_HI = 15;
	localparam int SER_ADDR_LO = 12;

	localparam logic [WORD_W-1:0] FULL_SCALE_LOW  = 14'h0000;
	localparam logic [WORD_W-1:0] FULL_SCALE_HIGH = 14'h3fff;

	typedef struct packed {
		logic              flag;
		logic [WORD_W-1:0] word;
	} aoc_out_s;

	typedef enum logic {
		SER_IDLE,
		SER_SHIFT
	} aoc_ser_e;
endpackage

// [rtl/aoc_sync.sv]
`timescale 1ns/1ps
module aoc_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule

// [rtl/aoc_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - After reset the phase loop is active; bypass applies only once software programs it.
// - In either loop mode the block powers down when the sample clock is absent or too slow.
// - Each result is a 14-bit word, bit 13 most significant and bit 0 least significant.
// - A data-ready clock is driven alongside the word so the receiver can latch it.
// - The range flag is high when the word sits at either full-scale limit, low otherwise.
// - A four-way select picks offset binary or twos complement and the latching edge.
// - The output enable is active high; low floats the word and flag outputs.
// - Reset returns registers and the datapath valid bits to their initial state, outputs low; the pipe words keep their values.
// - Mode registers are programmed over a three-wire serial interface.
// - Each word appears 16.5 sample clock periods after the sample that produced it.
// - Programmed power-down floats the word and flag outputs and holds the ready clock low.
module aoc_top (
	input  wire logic                              clock,
	input  wire logic                              reset,
	input  wire logic [aoc_pkg::REG_ADDR_W-1:0]    reg_addr,
	input  wire logic [aoc_pkg::REG_DATA_W-1:0]    reg_wdata,
	input  wire logic                              reg_write,
	input  wire logic                              reg_read,
	output logic      [aoc_pkg::REG_DATA_W-1:0]    reg_rdata,
	input  wire logic                              sample_clk,
	input  wire logic [aoc_pkg::WORD_W-1:0]        conversion_word,
	input  wire logic [aoc_pkg::FMT_W-1:0]         format_polarity_select,
	input  wire logic                              output_enable,
	input  wire logic                              serial_enable_n,
	input  wire logic                              serial_clk,
	input  wire logic                              serial_data,
	output logic      [aoc_pkg::WORD_W-1:0]        sample_word_out,
	output logic                                   sample_word_oe,
	output logic                                   range_exceeded_flag_out,
	output logic                                   range_exceeded_flag_oe,
	output logic                                   sample_ready_clk
);
	localparam int PINS_W = 5 + aoc_pkg::FMT_W + aoc_pkg::WORD_W;

	logic [PINS_W-1:0]               pins_s;
	logic                            sclk_s;
	logic                            oe_s;
	logic                            sen_n_s;
	logic                            sen_act_s;
	logic                            ser_clk_s;
	logic                            ser_dat_s;
	logic [aoc_pkg::FMT_W-1:0]       fmt_s;
	logic [aoc_pkg::WORD_W-1:0]      conv_s;
	logic                            sclk_d_reg;
	logic                            ser_clk_d_reg;
	logic                            sen_n_d_reg;
	logic                            rise;
	logic                            fall;
	logic                            any_edge;
	logic [1:0]                      ctrl_reg;
	logic [aoc_pkg::IDLE_W-1:0]      idle_reg;
	logic                            clk_ok_reg;
	logic [aoc_pkg::LOCK_W-1:0]      lock_cnt_reg;
	logic                            locked;
	logic                            pd;
	aoc_pkg::aoc_out_s               pipe_reg [0:aoc_pkg::LATENCY_HALF-1];
	logic [aoc_pkg::LATENCY_HALF-1:0] pipe_v_reg;
	aoc_pkg::aoc_out_s               ins;
	aoc_pkg::aoc_ser_e               ser_state_reg;
	logic [aoc_pkg::SERIAL_BITS-1:0] ser_shift_reg;
	logic [aoc_pkg::SER_CNT_W-1:0]   ser_cnt_reg;
	logic                            ser_done;

	aoc_sync #(.W(PINS_W)) u_sync (
		.clock (clock),
		.reset (reset),
		.d     ({sample_clk, output_enable, ~serial_enable_n, serial_clk, serial_data,
			format_polarity_select, conversion_word}),
		.q     (pins_s)
	);

	assign {sclk_s, oe_s, sen_act_s, ser_clk_s, ser_dat_s, fmt_s, conv_s} = pins_s;
	assign sen_n_s = ~sen_act_s;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sclk_d_reg    <= 1'b0;
			ser_clk_d_reg <= 1'b0;
			sen_n_d_reg   <= 1'b1;
		end else begin
			sclk_d_reg    <= sclk_s;
			ser_clk_d_reg <= ser_clk_s;
			sen_n_d_reg   <= sen_n_s;
		end
	end

	// Both sample clock edges advance the datapath by half a period.
	assign rise     = sclk_s & ~sclk_d_reg;
	assign fall     = ~sclk_s & sclk_d_reg;
	assign any_edge = rise | fall;

	// Three-wire frame: 16 bits, address in the top nibble, written on enable release.
	assign ser_done = (ser_state_reg == aoc_pkg::SER_SHIFT) && sen_n_s && !sen_n_d_reg &&
		(ser_cnt_reg == 5'(aoc_pkg::SERIAL_BITS));

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ser_state_reg <= aoc_pkg::SER_IDLE;
			ser_shift_reg <= 16'h0000;
			ser_cnt_reg   <= '0;
		end else begin
			case (ser_state_reg)
				aoc_pkg::SER_IDLE: begin
					ser_cnt_reg <= '0;
					if (!sen_n_s) begin
						ser_state_reg <= aoc_pkg::SER_SHIFT;
					end
				end
				aoc_pkg::SER_SHIFT: begin
					if (sen_n_s) begin
						ser_state_reg <= aoc_pkg::SER_IDLE;
					end else if (ser_clk_s && !ser_clk_d_reg &&
						ser_cnt_reg != 5'(aoc_pkg::SERIAL_BITS)) begin
						ser_shift_reg <= {ser_shift_reg[aoc_pkg::SERIAL_BITS-2:0], ser_dat_s};
						ser_cnt_reg   <= ser_cnt_reg + 5'h01;
					end
				end
				default: ser_state_reg <= aoc_pkg::SER_IDLE;
			endcase
		end
	end

	// Loop active from reset; only an explicit write selects bypass.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ctrl_reg <= aoc_pkg::CTRL_RESET;
		end else if (reg_write && reg_addr == aoc_pkg::ADDR_CTRL) begin
			ctrl_reg <= reg_wdata[1:0];
		end else if (ser_done &&
			ser_shift_reg[aoc_pkg::SER_ADDR_HI:aoc_pkg::SER_ADDR_LO] == aoc_pkg::ADDR_CTRL) begin
			ctrl_reg <= ser_shift_reg[1:0];
		end
	end

	// A clock slower than the loss window counts as absent, in either loop mode.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			idle_reg   <= '0;
			clk_ok_reg <= 1'b0;
		end else if (rise) begin
			idle_reg   <= '0;
			clk_ok_reg <= 1'b1;
		end else if (idle_reg == 6'(aoc_pkg::CLOCK_LOSS_CYCLES)) begin
			clk_ok_reg <= 1'b0;
		end else begin
			idle_reg <= idle_reg + 6'h01;
		end
	end

	assign pd = ctrl_reg[aoc_pkg::CTRL_PD_BIT] | ~clk_ok_reg;

	// The active loop needs a run of edges before its output is trusted; bypass does not.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			lock_cnt_reg <= '0;
		end else if (pd) begin
			lock_cnt_reg <= '0;
		end else if (rise && lock_cnt_reg != 4'(aoc_pkg::LOCK_EDGES)) begin
			lock_cnt_reg <= lock_cnt_reg + 4'h1;
		end
	end

	assign locked = ctrl_reg[aoc_pkg::CTRL_BYPASS_BIT] ||
		lock_cnt_reg == 4'(aoc_pkg::LOCK_EDGES);

	// Coding and range check happen at capture so the pipe carries finished words.
	always_comb begin
		ins.flag = (conv_s == aoc_pkg::FULL_SCALE_LOW) || (conv_s == aoc_pkg::FULL_SCALE_HIGH);
		ins.word = conv_s;
		if (fmt_s[aoc_pkg::FMT_TWOS_BIT]) begin
			ins.word[aoc_pkg::WORD_W-1] = ~conv_s[aoc_pkg::WORD_W-1];
		end
	end

	// Half-period pipe: a word taken on a rising edge leaves 33 edges later.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pipe_v_reg <= '0;
		end else if (pd) begin
			pipe_v_reg <= '0;
		end else if (any_edge) begin
			pipe_v_reg <= {pipe_v_reg[aoc_pkg::LATENCY_HALF-2:0], rise};
		end
	end

	always_ff @(posedge clock) begin
		if (any_edge) begin
			pipe_reg[0] <= ins;
			for (int i = 1; i < aoc_pkg::LATENCY_HALF; i++) begin
				pipe_reg[i] <= pipe_reg[i-1];
			end
		end
	end

	// Reset forces the word low; one update per sample period.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sample_word_out         <= '0;
			range_exceeded_flag_out <= 1'b0;
		end else if (any_edge && !pd && locked && pipe_v_reg[aoc_pkg::LATENCY_HALF-1]) begin
			sample_word_out         <= pipe_reg[aoc_pkg::LATENCY_HALF-1].word;
			range_exceeded_flag_out <= pipe_reg[aoc_pkg::LATENCY_HALF-1].flag;
		end
	end

	// Words change on the falling sample edge, so the ready clock follows the sample clock
	// when latching on its rise and the inverse otherwise.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sample_ready_clk <= 1'b0;
		end else if (pd) begin
			sample_ready_clk <= 1'b0;
		end else begin
			sample_ready_clk <= sclk_s ^ fmt_s[aoc_pkg::FMT_FALL_BIT];
		end
	end

	// Float word and flag when disabled or powered down.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sample_word_oe         <= 1'b0;
			range_exceeded_flag_oe <= 1'b0;
		end else begin
			sample_word_oe         <= oe_s & ~pd;
			range_exceeded_flag_oe <= oe_s & ~pd;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			reg_rdata <= 16'h0000;
		end else if (reg_read && reg_addr == aoc_pkg::ADDR_CTRL) begin
			reg_rdata <= {14'h0000, ctrl_reg};
		end else if (reg_read && reg_addr == aoc_pkg::ADDR_STATUS) begin
			reg_rdata <= {11'h000, ctrl_reg[aoc_pkg::CTRL_BYPASS_BIT], range_exceeded_flag_out,
				locked, pd, clk_ok_reg};
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	property p_flag_limits;
		any_edge |=> pipe_reg[0].flag == ($past(conv_s) == aoc_pkg::FULL_SCALE_LOW ||
			$past(conv_s) == aoc_pkg::FULL_SCALE_HIGH);
	endproperty
	a_flag_limits: assert property (p_flag_limits) else $error("range flag wrong");

	property p_oe_low;
		!oe_s |=> !sample_word_oe && !range_exceeded_flag_oe;
	endproperty
	a_oe_low: assert property (p_oe_low) else $error("outputs driven while disabled");

	property p_pd_float;
		ctrl_reg[aoc_pkg::CTRL_PD_BIT] |=> !sample_word_oe ##0 !sample_ready_clk;
	endproperty
	a_pd_float: assert property (p_pd_float) else $error("outputs driven in power-down");

	property p_clock_loss;
		!rise && idle_reg == 6'(aoc_pkg::CLOCK_LOSS_CYCLES) |=> !clk_ok_reg;
	endproperty
	a_clock_loss: assert property (p_clock_loss) else $error("lost clock not seen");

	property p_bypass_cause;
		$rose(ctrl_reg[aoc_pkg::CTRL_BYPASS_BIT]) |-> $past(reg_write) || $past(ser_done);
	endproperty
	a_bypass_cause: assert property (p_bypass_cause) else $error("bypass without write");

	property p_latency;
		any_edge && !pd && locked && pipe_v_reg[aoc_pkg::LATENCY_HALF-1] |=>
			sample_word_out == $past(pipe_reg[aoc_pkg::LATENCY_HALF-1].word) &&
			range_exceeded_flag_out == $past(pipe_reg[aoc_pkg::LATENCY_HALF-1].flag);
	endproperty
	a_latency: assert property (p_latency) else $error("word not updated");

	property p_ready_follow;
		rise && !pd && !fmt_s[aoc_pkg::FMT_FALL_BIT] ##1 !pd |-> sample_ready_clk;
	endproperty
	a_ready_follow: assert property (p_ready_follow) else $error("ready clock late");

	property p_serial_write;
		ser_done && !reg_write &&
			ser_shift_reg[aoc_pkg::SER_ADDR_HI:aoc_pkg::SER_ADDR_LO] == aoc_pkg::ADDR_CTRL
			|=> ctrl_reg == $past(ser_shift_reg[1:0]);
	endproperty
	a_serial_write: assert property (p_serial_write) else $error("serial write lost");

	property p_status_read;
		reg_read && reg_addr == aoc_pkg::ADDR_STATUS |=>
			reg_rdata[aoc_pkg::STAT_PD_BIT] == $past(pd);
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read wrong");

	c_word_out: cover property (any_edge && locked && pipe_v_reg[aoc_pkg::LATENCY_HALF-1]);
	c_clock_loss: cover property (clk_ok_reg ##1 !clk_ok_reg);
	c_serial: cover property (ser_done);
	c_flag: cover property ($rose(range_exceeded_flag_out));
endmodule

// [testbench/aoc_capture_model.sv]
`timescale 1ns/1ps
module aoc_capture_model (
	input  wire logic                       run,
	input  wire logic [1:0]                 fmt,
	input  wire logic [aoc_pkg::WORD_W-1:0] word_in,
	input  wire logic                       flag_in,
	input  wire logic                       ready_clk,
	output logic                            sample_clk,
	output logic      [aoc_pkg::WORD_W-1:0] conv_word,
	output logic      [aoc_pkg::WORD_W-1:0] cap_word,
	output logic                            cap_flag,
	output logic      [aoc_pkg::WORD_W-1:0] ref_raw,
	output int                              n_cap
);
	logic [aoc_pkg::WORD_W-1:0] taken [$];

	// The clock stands low while stopped and resumes off the system clock grid.
	initial begin
		sample_clk = 1'b0;
		conv_word  = 14'h0000;
		n_cap      = 0;
		#13;
		forever begin
			if (run) begin
				sample_clk = 1'b1;
				taken.push_back(conv_word);
				#200;
				sample_clk = 1'b0;
				// Changing the word mid-period keeps it steady around every rising edge.
				case (taken.size() % 5)
					0: conv_word = 14'h0000;
					1: conv_word = 14'h3fff;
					default: conv_word = 14'(taken.size()) * 14'h0123;
				endcase
				#200;
			end else begin
				// Polling in steps of 10 keeps every clock edge off both system clock edges.
				#10;
			end
		end
	end

	// Only words old enough to have crossed the whole pipeline get a reference.
	always @(ready_clk) begin
		if (ready_clk !== fmt[1] && taken.size() > 17) begin
			cap_word = word_in;
			cap_flag = flag_in;
			ref_raw  = taken[taken.size() - 18];
			n_cap++;
		end
	end
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
	logic                           clock = 1'b0;
	logic                           reset = 1'b1;
	logic [aoc_pkg::REG_ADDR_W-1:0] reg_addr = 4'h0;
	logic [aoc_pkg::REG_DATA_W-1:0] reg_wdata = 16'h0000;
	logic                           reg_write = 1'b0;
	logic                           reg_read = 1'b0;
	logic [aoc_pkg::REG_DATA_W-1:0] reg_rdata;
	logic [1:0]                     fmt = 2'b00;
	logic                           output_enable = 1'b0;
	logic                           serial_enable_n = 1'b1;
	logic                           serial_clk = 1'b0;
	logic                           serial_data = 1'b0;
	logic                           run = 1'b0;
	logic                           chk = 1'b0;
	logic                           sample_clk;
	logic [aoc_pkg::WORD_W-1:0]     conv_word, word_out, word_bus, cap_word, ref_raw;
	logic                           word_oe, flag_out, flag_oe, flag_bus, ready_clk, cap_flag;
	int                             n_cap, n_errors = 0, checked = 0;

	aoc_top i_dut (
		.clock                  (clock),
		.reset                  (reset),
		.reg_addr               (reg_addr),
		.reg_wdata              (reg_wdata),
		.reg_write              (reg_write),
		.reg_read               (reg_read),
		.reg_rdata              (reg_rdata),
		.sample_clk             (sample_clk),
		.conversion_word        (conv_word),
		.format_polarity_select (fmt),
		.output_enable          (output_enable),
		.serial_enable_n        (serial_enable_n),
		.serial_clk             (serial_clk),
		.serial_data            (serial_data),
		.sample_word_out        (word_out),
		.sample_word_oe         (word_oe),
		.range_exceeded_flag_out(flag_out),
		.range_exceeded_flag_oe (flag_oe),
		.sample_ready_clk       (ready_clk)
	);

	// A floating line shows the inverse so a stale value can never pass.
	assign word_bus = word_oe ? word_out : ~word_out;
	assign flag_bus = flag_oe ? flag_out : ~flag_out;

	aoc_capture_model i_cap (
		.run       (run),
		.fmt       (fmt),
		.word_in   (word_bus),
		.flag_in   (flag_bus),
		.ready_clk (ready_clk),
		.sample_clk(sample_clk),
		.conv_word (conv_word),
		.cap_word  (cap_word),
		.cap_flag  (cap_flag),
		.ref_raw   (ref_raw),
		.n_cap     (n_cap)
	);

	always #25 clock = ~clock;

	always @(n_cap) begin
		if (chk) begin
			`CHK(cap_word, ref_raw ^ {fmt[0], 13'h0000})
			`CHK(cap_flag, ref_raw == 14'h0000 || ref_raw == 14'h3fff)
		end
	end

	task automatic summarize();
		if (n_errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	task automatic expect_reg(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		`CHK(reg_rdata & m, e)
	endtask

	task automatic ser(input logic [15:0] v, input int n);
		@(posedge clock);
		serial_enable_n <= 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			serial_data <= v[i];
			repeat (4) @(posedge clock);
			serial_clk <= 1'b1;
			repeat (4) @(posedge clock);
			serial_clk <= 1'b0;
		end
		repeat (4) @(posedge clock);
		serial_enable_n <= 1'b1;
		serial_data <= ~serial_data;
		repeat (8) @(posedge clock);
	endtask

	// The window spans exactly ten sample periods, so exactly ten latches fall in it.
	task automatic window(input logic [1:0] mode);
		int n0;
		@(posedge clock);
		fmt <= mode;
		cyc(192);
		chk = 1'b1;
		n0 = n_cap;
		cyc(80);
		chk = 1'b0;
		`CHK(n_cap - n0, 10)
	endtask

	initial begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		cyc(0);
		`CHK({word_out, word_oe, flag_out, flag_oe, ready_clk}, 18'h0_0000)
		expect_reg(aoc_pkg::ADDR_CTRL, 16'hffff, 16'h0000);
		expect_reg(4'h7, 16'hffff, 16'h0000);
		@(posedge clock);
		run <= 1'b1;
		output_enable <= 1'b1;
		cyc(96);
		expect_reg(aoc_pkg::ADDR_STATUS, 16'h0017, 16'h0005);
		for (int m = 0; m < 4; m++) begin
			window(2'(m));
		end
		@(posedge clock);
		output_enable <= 1'b0;
		cyc(4);
		`CHK({word_oe, flag_oe}, 2'b00)
		@(posedge clock);
		output_enable <= 1'b1;
		wr(aoc_pkg::ADDR_CTRL, 16'h0002);
		cyc(4);
		`CHK({word_oe, flag_oe, ready_clk}, 3'b000)
		expect_reg(aoc_pkg::ADDR_STATUS, 16'h0002, 16'h0002);
		wr(aoc_pkg::ADDR_CTRL, 16'h0000);
		ser(16'h0001, 16);
		expect_reg(aoc_pkg::ADDR_CTRL, 16'hffff, 16'h0001);
		ser(16'h0002, 15);
		wr(4'h9, 16'h0003);
		expect_reg(aoc_pkg::ADDR_CTRL, 16'hffff, 16'h0001);
		expect_reg(aoc_pkg::ADDR_STATUS, 16'h0010, 16'h0010);
		window(2'b01);
		@(posedge clock);
		run <= 1'b0;
		cyc(40);
		`CHK(ready_clk, 1'b0)
		expect_reg(aoc_pkg::ADDR_STATUS, 16'h0003, 16'h0002);
		@(posedge clock);
		run <= 1'b1;
		cyc(100);
		@(posedge clock);
		reset <= 1'b1;
		cyc(40);
		`CHK({word_out, word_oe, flag_out, flag_oe, ready_clk}, 18'h0_0000)
		@(posedge clock);
		reset <= 1'b0;
		expect_reg(aoc_pkg::ADDR_CTRL, 16'hffff, 16'h0000);
		summarize();
	end

	initial begin
		repeat (8000) @(posedge clock);
		n_errors++;
		summarize();
	end
endmodule
